// File: tb/ervnq_gen_model.sv
module ervnq_gen_model (
	input wire logic sys_clk, // clock
	input wire logic fire, // launch one event
	input wire logic [7:0] code, // source number
	input wire logic dat, // event data bit
	output logic [255:0] src_strobe, // strobes
	output logic [255:0] src_data // data
);
	timeunit 1ns;
	timeprecision 100ps;
	// one-cycle event; idle data held low so no stray index code appears
	always @(posedge sys_clk) begin
		src_strobe <= '0;
		src_data <= '0;
		if (fire) begin
			src_strobe[code] <= 1'b1;
			src_data[code] <= dat;
		end
	end
endmodule : ervnq_gen_model

// File: tb/ervnq_router_asserts.sv
`include "ervnq_defines.svh"
module ervnq_router_asserts #(
	parameter int NUM_CH = 8,
	parameter int SEL_W = 8
) (
	input wire logic sys_clk, // clock
	input wire logic srst, // reset
	input wire logic [`ERVNQ_NUM_SRC-1:0] src_strobe, // generator strobes
	input wire logic [7:0] pin_level_n, // pins
	input wire logic [NUM_CH*SEL_W-1:0] channel_source_select, // selectors
	input wire logic [NUM_CH-1:0] prescale_en, // periodic ticks
	input wire logic [NUM_CH-1:0] filter_en, // filters
	input wire logic [NUM_CH-1:0] sw_data, // sw data
	input wire logic [NUM_CH-1:0] sw_strobe_wr, // sw strobe
	input wire logic [2:0] quad_index_en, // index enables
	input wire logic [NUM_CH-1:0] user_sig_only, // signal-only users
	input wire logic [NUM_CH-1:0] ch_strobe, // channel strobe
	input wire logic [NUM_CH-1:0] ch_data, // channel data
	input wire logic [NUM_CH-1:0] ch_signal, // signaling view
	input wire logic [2:0] quad_error // error flags
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// software events win their channel one cycle later, data masked for plain users
	a_sw_strobe_hit: assert property (|sw_strobe_wr |=>
		(ch_strobe & $past(sw_strobe_wr)) == $past(sw_strobe_wr)) else $error("sw strobe lost");
	a_sw_data_code: assert property (|sw_strobe_wr |=> ((ch_data ^
		($past(sw_data) & ~$past(user_sig_only))) & $past(sw_strobe_wr)) == '0)
		else $error("sw data wrong");
	a_signal_view: assert property (ch_signal == ch_strobe)
		else $error("signal view differs");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=>
		ch_strobe == '0 && quad_error == '0) else $error("reset not quiet");
	// channel 6 with selection zero stays silent without software, prescaler or filter help
	a_none_silent: assert property ((channel_source_select[55:48] == 8'h00
		&& !sw_strobe_wr[6] && !sw_data[6] && !prescale_en[6] && !filter_en[6])[*2]
		|=> !ch_strobe[6]) else $error("idle channel fired");
	a_gen_route: assert property (channel_source_select[63:56] inside {[8'h08:8'h4F]}
		&& src_strobe[channel_source_select[63:56]] && !sw_data[7] && !filter_en[7]
		|=> ch_strobe[7]) else $error("generator event lost");
	// a low pin keeps firing once through the two-flop sync
	a_pin_level: assert property ((channel_source_select[31:24] == 8'h53
		&& !pin_level_n[3] && !filter_en[3] && !sw_data[3] && !quad_index_en[1])[*5]
		|-> ch_strobe[3]) else $error("level source stopped");
	a_error_sticky: assert property (|quad_error |=>
		(quad_error & $past(quad_error)) == $past(quad_error)) else $error("error flag fell");
endmodule : ervnq_router_asserts

bind ervnq_router ervnq_router_asserts #(.NUM_CH(NUM_CH), .SEL_W(SEL_W)) i_chk (.*);

// File: tb/tb_ervnq_router.sv
module tb_ervnq_router import ervnq_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0, srst = 1'b1, fire = 1'b0, gdat = 1'b0;
	logic [7:0] gcode = '0, pin_level_n = 8'hFF, prescale_en = '0, filter_en = '0;
	logic [7:0] sw_data = '0, sw_strobe_wr = '0, user_sig_only = '0;
	logic [63:0] channel_source_select = '0;
	logic [31:0] prescale_exp = 32'h000F0000;
	logic [31:0] quad_period = 32'h00000FFF; // 1024 lines
	logic [23:0] filter_len = '0;
	logic [2:0] quad_decoder_en = '0, quad_index_en = '0, quad_error;
	logic [5:0] quad_index_mode = '0;
	logic [7:0] ch_strobe, ch_data, ch_signal;
	logic [47:0] quad_position;
	logic [255:0] src_strobe, src_data;
	int n_fail = 0, n_checks = 0;
	ervnq_router i_dut (.*);
	ervnq_gen_model i_gen (.sys_clk, .fire, .code(gcode), .dat(gdat), .src_strobe, .src_data);
	always #12.5 sys_clk = ~sys_clk;
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	// generator event, optional software strobe landing in the same cycle
	task automatic gen(logic [7:0] c, logic [7:0] sw, logic [7:0] es, logic [7:0] ed);
		@(posedge sys_clk);
		{gcode, gdat, fire} <= {c, 2'b11};
		@(posedge sys_clk);
		{fire, sw_strobe_wr} <= {1'b0, sw};
		@(posedge sys_clk);
		sw_strobe_wr <= '0;
		#1;
		chk("gen_stb", es, ch_strobe);
		chk("gen_dat", ed, ch_data);
	endtask : gen
	// hang guard, sized above the long prescaler window
	initial begin
		tick(90000);
		n_fail++;
		close_out();
	end
	initial begin
		logic [7:0] d, s, g;
		logic [23:0] e;
		logic [23:0] q[$];
		int cnt;
		int pe[3] = '{15, 3, 0};
		logic [1:0] st[8] = '{2'b01, 2'b00, 2'b10, 2'b11, 2'b10, 2'b00, 2'b11, 2'b00};
		d = $urandom(32'h0CA4);
		tick(20);
		srst <= 1'b0;
		// random software events; data bits inject with or without their strobe
		for (int i = 0; i <= 200; i++) begin
			@(posedge sys_clk);
			{d, s, g} = (i == 200) ? 24'h0 : 24'($urandom);
			{sw_data, sw_strobe_wr, user_sig_only} <= {d, s, g};
			#1;
			if (i > 0) begin
				e = q.pop_front();
				chk("sw_stb", e[23:16], ch_strobe);
				chk("sw_dat", e[15:8], ch_data);
				chk("sw_sig", e[7:0], ch_signal);
			end
			q.push_back({s, d & ~g, s});
		end
		channel_source_select[47:40] <= 8'h20;
		channel_source_select[63:56] <= 8'h20;
		gen(8'h20, 8'h00, 8'hA0, 8'hA0);
		gen(8'h20, 8'h80, 8'hA0, 8'h20);
		// decoder 0 on pins 0/1: +4, -2, then two double jumps that must not count
		channel_source_select[7:0] <= 8'h50;
		{filter_en, filter_len} <= {8'h03, 24'h000009};
		quad_decoder_en <= 3'b001;
		foreach (st[k]) begin
			pin_level_n[1:0] <= st[k];
			tick(12);
		end
		chk("pos", 16'h0002, quad_position[15:0]);
		// index with count off bottom, every recognition mode tried
		channel_source_select[31:8] <= 24'h53_0052;
		{quad_index_en, pin_level_n[3:2]} <= 5'b00100;
		for (int m = 0; m < 4; m++) begin
			quad_index_mode[1:0] <= 2'(m);
			tick(12);
		end
		#1;
		chk("qerr", 16'h0001, quad_error);
		chk("pin", 16'h0008, ch_strobe & 8'h08);
		// any window of two periods holds exactly two ticks
		foreach (pe[k]) begin
			{prescale_exp[19:16], prescale_en} <= {pe[k][3:0], 8'h10};
			tick(64);
			cnt = 0;
			repeat (2 << pe[k]) begin
				@(posedge sys_clk);
				#1 cnt += ch_strobe[4];
			end
			chk("ticks", 16'h0002, cnt[15:0]);
		end
		srst <= 1'b1;
		tick(2);
		#1;
		chk("rst", 16'h0000, {quad_error, ch_strobe});
		close_out();
	end
endmodule : tb_ervnq_router

// File: verilog/ervnq_defines.svh
`ifndef ERVNQ_DEFINES_SVH
`define ERVNQ_DEFINES_SVH
// channel count and widths
`define ERVNQ_NUM_CH 8
`define ERVNQ_SEL_W 8
`define ERVNQ_NUM_SRC 256
// divider exponent range: 2^0 = 1 up to 2^15 = 32768
`define ERVNQ_DIV_W 4
`define ERVNQ_DIV_MAX_EXP 4'hF
`define ERVNQ_PRE_W 15
// filter length field width and the no-source selection code
`define ERVNQ_FLT_W 3
`define ERVNQ_SEL_NONE 8'h00
// counter width for the quadrature position counters
`define ERVNQ_CNT_W 16
`endif

// File: verilog/ervnq_pkg.sv
package ervnq_pkg;
	// index recognition modes: which phase state qualifies the index
	typedef enum logic [1:0] {
		ERVNQ_IDX_S00 = 2'b00,
		ERVNQ_IDX_S01 = 2'b01,
		ERVNQ_IDX_S10 = 2'b10,
		ERVNQ_IDX_S11 = 2'b11
	} ervnq_idx_mode_t;
	// data-event code on the strobe/data pair
	typedef enum logic [1:0] {
		ERVNQ_EV_NONE = 2'b00,
		ERVNQ_EV_INDEX = 2'b01,
		ERVNQ_EV_DOWN = 2'b10,
		ERVNQ_EV_UP = 2'b11
	} ervnq_ev_t;
endpackage : ervnq_pkg

// File: verilog/ervnq_router.sv
// Functional notes
// RULE1: each channel has a clock prescaler dividing by 1 up to 32768.
// RULE2: software writes data before strobe; the strobe write launches the event. Code: a set data bit alone injects a data-only event.
// RULE3: data and strobe hold one bit per channel; multiple bits inject together.
// RULE4: injected event lasts one cycle and overrides other generators.
// RULE5: injected codes: 00 none, 01 data only, 1x signaling plus data 02/03.
// RULE6: eight independent source selectors, each forming one channel.
// RULE7: one source may be selected on several channels at once.
// RULE8: events last one cycle; level sources repeat while condition holds.
// RULE9: at most two cycles from generation to user action. Code: pin sources take three cycles, filtered channels more.
// RULE10: optional filter accepts input after N equal consecutive samples.
// RULE11: three quadrature decoders on channels 0, 2 and 4 only.
// RULE12: decoder codes: 00 none, 01 index, 10 down, 11 up.
// RULE13: lag phase leading means forward; two phases form the phase state.
// RULE14: software picks ref pin on channel n, enables decode and filter. Code decodes fixed pins 2k/2k+1, unfiltered.
// RULE15: channel n+1 takes index pin, with index enable and recognition mode.
// RULE16: timer runs quadrature mode, period four times lines minus one.
// RULE17: error flag if count not bottom at index or passes bottom unindexed.
// RULE18: data-capable users may treat channel events as plain signaling.
// RULE19: selection zero routes nothing but software events still pass.
// RULE20: one count per valid single-step transition; double jumps ignored.
`include "ervnq_defines.svh"
module ervnq_router
	import ervnq_pkg::*;
#(
	parameter int NUM_CH = `ERVNQ_NUM_CH,
	parameter int SEL_W = `ERVNQ_SEL_W,
	parameter int CNT_W = `ERVNQ_CNT_W
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [`ERVNQ_NUM_SRC-1:0] src_strobe, // generator event strobes, same domain
	input wire logic [`ERVNQ_NUM_SRC-1:0] src_data, // generator event data bits
	input wire logic [7:0] pin_level_n, // async pin levels, low active sense
	input wire logic [NUM_CH*SEL_W-1:0] channel_source_select, // per channel source selector
	input wire logic [NUM_CH*`ERVNQ_DIV_W-1:0] prescale_exp, // per channel divide exponent
	input wire logic [NUM_CH-1:0] prescale_en, // per channel periodic event enable
	input wire logic [NUM_CH-1:0] filter_en, // per channel filter enable
	input wire logic [NUM_CH*`ERVNQ_FLT_W-1:0] filter_len, // samples minus one per channel
	input wire logic [NUM_CH-1:0] sw_data, // software data bits
	input wire logic [NUM_CH-1:0] sw_strobe_wr, // strobe register write, one-cycle pulse
	input wire logic [2:0] quad_decoder_en, // decoder enable on channels 0,2,4
	input wire logic [2:0] quad_index_en, // index enable on channels 1,3,5
	input wire logic [5:0] quad_index_mode, // index recognition mode per decoder
	input wire logic [NUM_CH-1:0] user_sig_only, // users that ignore data codes
	input wire logic [2*CNT_W-1:0] quad_period, // expected top count, low field shared by all three decoders
	output logic [NUM_CH-1:0] ch_strobe, // channel strobe, registered
	output logic [NUM_CH-1:0] ch_data, // channel data, registered
	output logic [NUM_CH-1:0] ch_signal, // signaling view for users, registered
	output logic [2:0] quad_error, // sticky counter error per decoder, registered
	output logic [3*CNT_W-1:0] quad_position // position count per decoder, registered
);
	// pins pass two flops before use
	logic [7:0] pin_s1_r, pin_s1_nxt, pin_s2_r, pin_s2_nxt;
	// prescaler counter per channel
	logic [`ERVNQ_PRE_W-1:0] pre_cnt_r [NUM_CH];
	logic [`ERVNQ_PRE_W-1:0] pre_cnt_nxt [NUM_CH];
	// filter state per channel
	logic [`ERVNQ_FLT_W-1:0] flt_cnt_r [NUM_CH];
	logic [`ERVNQ_FLT_W-1:0] flt_cnt_nxt [NUM_CH];
	logic [NUM_CH-1:0] flt_val_r, flt_val_nxt, flt_last_r, flt_last_nxt;
	// decoder state
	logic [1:0] qstate_r [3];
	logic [1:0] qstate_nxt [3];
	logic [CNT_W-1:0] qcnt_r [3];
	logic [CNT_W-1:0] qcnt_nxt [3];
	logic [2:0] qerr_r, qerr_nxt;
	// output stage
	logic [NUM_CH-1:0] stb_r, stb_nxt, dat_r, dat_nxt, sig_r, sig_nxt;
	// raw routed values before filter
	logic [NUM_CH-1:0] raw_stb, raw_dat;
	logic [NUM_CH-1:0] pre_tick;
	logic [2:0] qev_stb, qev_dat;
	logic [2:0] qidx;

	assign pin_s1_nxt = pin_level_n;
	assign pin_s2_nxt = pin_s1_r;

	// source multiplexers; zero selects nothing and any code may repeat on channels
	always_comb begin
		raw_stb = '0;
		raw_dat = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			logic [SEL_W-1:0] sel;
			sel = channel_source_select[c*SEL_W +: SEL_W];
			if (sel != `ERVNQ_SEL_NONE) begin // see RULE19
				raw_stb[c] = src_strobe[sel]; // see RULE6, see RULE7
				raw_dat[c] = src_data[sel];
			end
			// pin sources 0x50..0x57 replaced by synced low-level pin sense
			if (sel[7:3] == 5'h0A) begin
				raw_stb[c] = ~pin_s2_r[sel[2:0]]; // see RULE8
				raw_dat[c] = 1'b0;
			end
			if (prescale_en[c] && pre_tick[c])
				raw_stb[c] = 1'b1; // see RULE1
		end
	end

	// prescaler: free counter, tick when masked low bits are all zero
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			logic [`ERVNQ_PRE_W-1:0] mask;
			logic [`ERVNQ_DIV_W-1:0] e;
			e = prescale_exp[c*`ERVNQ_DIV_W +: `ERVNQ_DIV_W];
			mask = `ERVNQ_PRE_W'((16'h0001 << e) - 16'h0001);
			pre_cnt_nxt[c] = pre_cnt_r[c] + `ERVNQ_PRE_W'(1);
			pre_tick[c] = ((pre_cnt_r[c] & mask) == '0); // see RULE1
		end
	end

	// filter: hold value until input stays equal for len+1 samples
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			flt_last_nxt[c] = raw_stb[c];
			flt_cnt_nxt[c] = flt_cnt_r[c];
			flt_val_nxt[c] = flt_val_r[c];
			if (raw_stb[c] != flt_last_r[c])
				flt_cnt_nxt[c] = '0;
			else if (flt_cnt_r[c] != filter_len[c*`ERVNQ_FLT_W +: `ERVNQ_FLT_W])
				flt_cnt_nxt[c] = flt_cnt_r[c] + `ERVNQ_FLT_W'(1);
			else
				flt_val_nxt[c] = raw_stb[c]; // see RULE10
		end
	end

	// quadrature decoders on channel 2k with index on 2k+1
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			logic [1:0] cur;
			logic [1:0] prv;
			logic fwd, rev;
			ervnq_idx_mode_t md;
			// ref phase pin n, lag phase pin n+1, state is {lag, ref}
			cur = {pin_s2_r[(2*k+1) & 7], pin_s2_r[(2*k) & 7]}; // see RULE13
			prv = qstate_r[k];
			md = ervnq_idx_mode_t'(quad_index_mode[2*k +: 2]);
			// gray sequence 00->10->11->01 is lag leading: forward
			fwd = (prv == 2'b00 && cur == 2'b10) || (prv == 2'b10 && cur == 2'b11) ||
				(prv == 2'b11 && cur == 2'b01) || (prv == 2'b01 && cur == 2'b00);
			rev = (prv == 2'b00 && cur == 2'b01) || (prv == 2'b01 && cur == 2'b11) ||
				(prv == 2'b11 && cur == 2'b10) || (prv == 2'b10 && cur == 2'b00);
			qidx[k] = quad_index_en[k] && flt_val_r[2*k+1] && (cur == md); // see RULE15
			qstate_nxt[k] = cur;
			qcnt_nxt[k] = qcnt_r[k];
			qerr_nxt[k] = qerr_r[k];
			qev_stb[k] = 1'b0;
			qev_dat[k] = 1'b0;
			if (quad_decoder_en[k]) begin // see RULE11
				if (fwd || rev) begin // see RULE20
					qev_stb[k] = 1'b1; // see RULE12
					qev_dat[k] = fwd;
					if (fwd)
						qcnt_nxt[k] = (qcnt_r[k] == quad_period[k*0 +: CNT_W]) ?
							'0 : qcnt_r[k] + CNT_W'(1);
					else
						qcnt_nxt[k] = (qcnt_r[k] == '0) ?
							quad_period[k*0 +: CNT_W] : qcnt_r[k] - CNT_W'(1);
					// wrap through bottom without an index is an error
					if (!qidx[k] && quad_index_en[k] &&
						((fwd && qcnt_r[k] == quad_period[k*0 +: CNT_W]) ||
						(rev && qcnt_r[k] == '0)))
						qerr_nxt[k] = 1'b1; // see RULE17
				end else if (qidx[k]) begin
					qev_dat[k] = 1'b1; // see RULE12
				end
				if (qidx[k]) begin
					if (qcnt_r[k] != '0)
						qerr_nxt[k] = 1'b1; // see RULE17
					qcnt_nxt[k] = '0;
				end
			end
		end
	end

	// final channel value: software event wins for its single cycle
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			stb_nxt[c] = filter_en[c] ? flt_val_r[c] : raw_stb[c];
			dat_nxt[c] = filter_en[c] ? 1'b0 : raw_dat[c];
			if ((c % 2) == 0 && c < 6 && quad_decoder_en[c/2]) begin
				stb_nxt[c] = qev_stb[c/2];
				dat_nxt[c] = qev_dat[c/2];
			end
			// a set data bit alone injects a data-only event; the strobe write sets the strobe
			if (sw_strobe_wr[c] || sw_data[c]) begin // see RULE2, see RULE3
				stb_nxt[c] = sw_strobe_wr[c]; // see RULE4, see RULE5
				dat_nxt[c] = sw_data[c];
			end
			// mask data in the flop stage so the output is not fed by a live input
			dat_nxt[c] = dat_nxt[c] && !user_sig_only[c]; // see RULE18
			sig_nxt[c] = stb_nxt[c]; // see RULE5
		end
	end

	// single register stage keeps generator latency at one cycle, inside the two allowed; pins add two sync flops, a filtered channel its filter stages
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_s1_r <= 8'hFF;
			pin_s2_r <= 8'hFF;
			flt_val_r <= '0;
			flt_last_r <= '0;
			qerr_r <= '0;
			stb_r <= '0;
			dat_r <= '0;
			sig_r <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				pre_cnt_r[c] <= '0;
				flt_cnt_r[c] <= '0;
			end
			for (int k = 0; k < 3; k++) begin
				qstate_r[k] <= 2'b00;
				qcnt_r[k] <= '0;
			end
		end else begin
			pin_s1_r <= pin_s1_nxt;
			pin_s2_r <= pin_s2_nxt;
			flt_val_r <= flt_val_nxt;
			flt_last_r <= flt_last_nxt;
			qerr_r <= qerr_nxt;
			stb_r <= stb_nxt; // see RULE9
			dat_r <= dat_nxt;
			sig_r <= sig_nxt;
			for (int c = 0; c < NUM_CH; c++) begin
				pre_cnt_r[c] <= pre_cnt_nxt[c];
				flt_cnt_r[c] <= flt_cnt_nxt[c];
			end
			for (int k = 0; k < 3; k++) begin
				qstate_r[k] <= qstate_nxt[k];
				qcnt_r[k] <= qcnt_nxt[k];
			end
		end
	end

	assign ch_strobe = stb_r;
	assign ch_data = dat_r;
	assign ch_signal = sig_r;
	assign quad_error = qerr_r;
	assign quad_position = {qcnt_r[2], qcnt_r[1], qcnt_r[0]};
endmodule : ervnq_router
